// ### verilog/buck_boost_phase_sequencer.sv
// Switching-phase sequencer of the noninverting buck-boost converter with its configuration registers.
`timescale 1ns/100ps

module buck_boost_phase_sequencer #(
  parameter int TIMEOUT_CYC   = bb_seq_pkg::CHARGE_TIMEOUT_CYC,
  parameter int FREEWHEEL_CYC = bb_seq_pkg::FREEWHEEL_CYC,
  parameter int WINDOW_CYC    = bb_seq_pkg::FREQ_WINDOW_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  input  wire logic [7:0] lookupPrimary,
  input  wire logic [7:0] lookupSecondary,
  output logic      [3:0] primaryPeakLimit,
  output logic      [4:0] totalPeakLimit,
  input  wire logic       peakReached,
  input  wire logic       valleyReached,
  input  wire logic       zeroCrossed,
  input  wire logic       supplyAboveOutput,
  input  wire logic       chargeRequest,
  output logic            inputHighSwitch,
  output logic            outputHighSwitch,
  output logic            inputLowSwitch,
  output logic            outputLowSwitch,
  output logic      [2:0] phaseNumber,
  output logic            lowQuiescent
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  // Elaboration checks: the phase timers need a cycle at least and the freewheel must end before the timeout.
  if (TIMEOUT_CYC < 1 || FREEWHEEL_CYC < 1)
  begin : g_countCheck
    $error("sequencer: counts must be at least one");
  end
  if (FREEWHEEL_CYC >= TIMEOUT_CYC)
  begin : g_orderCheck
    $error("sequencer: freewheel must be shorter than timeout");
  end
  if (WINDOW_CYC < 8)
  begin : g_windowCheck
    $error("sequencer: frequency window too short");
  end

  logic [7:0] modeConfig_reg;
  logic [7:0] peakLimits_reg;
  logic [7:0] valleyConfig_reg;
  logic [7:0] freqConfig_reg;
  logic [7:0] regRdata_reg;
  bb_seq_pkg::phase_e phase_reg;
  bb_seq_pkg::phase_e phase_next;
  bb_seq_pkg::phase_e chargeEntry;
  logic [TW-1:0] timer_reg;
  logic [3:0] switches_reg;
  logic [3:0] switchesNext;
  logic       buckOnly;
  logic       zeroCrossSel;
  logic       lookupDisable;
  logic       timeout;
  logic       freewheelDone;
  logic       phaseChange;
  logic       cycleStartPulse;
  logic [3:0] primarySel;
  logic [3:0] secondarySel;

  // Carrier of cycle starts and the low-quiescent decision to and from the frequency comparator.
  freq_monitor_if fm ();

  // Register fields that steer the sequence.
  assign buckOnly      = modeConfig_reg[bb_seq_pkg::TOPOLOGY_BIT];
  assign lookupDisable = modeConfig_reg[bb_seq_pkg::LOOKUP_DIS_BIT];
  assign zeroCrossSel  = valleyConfig_reg[bb_seq_pkg::ZERO_CROSS_BIT];

  // Register writes through the documented register port.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      modeConfig_reg   <= bb_seq_pkg::MODE_CONFIG_RST;
      peakLimits_reg   <= bb_seq_pkg::PEAK_LIMITS_RST;
      valleyConfig_reg <= bb_seq_pkg::VALLEY_CONFIG_RST;
      freqConfig_reg   <= bb_seq_pkg::FREQ_CONFIG_RST;
    end
    else if (regWrite)
    begin
      case (regAddr)
        bb_seq_pkg::MODE_CONFIG_ADDR:   modeConfig_reg   <= regWdata;
        bb_seq_pkg::PEAK_LIMITS_ADDR:   peakLimits_reg   <= regWdata;
        bb_seq_pkg::VALLEY_CONFIG_ADDR: valleyConfig_reg <= regWdata;
        bb_seq_pkg::FREQ_CONFIG_ADDR:   freqConfig_reg   <= regWdata;
        default:                        ;
      endcase
    end
  end

  // Read data registered one cycle after the read strobe; unmapped addresses read zero.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      regRdata_reg <= 8'h00;
    else if (regRead)
    begin
      case (regAddr)
        bb_seq_pkg::MODE_CONFIG_ADDR:   regRdata_reg <= modeConfig_reg;
        bb_seq_pkg::PEAK_LIMITS_ADDR:   regRdata_reg <= peakLimits_reg;
        bb_seq_pkg::VALLEY_CONFIG_ADDR: regRdata_reg <= valleyConfig_reg;
        bb_seq_pkg::FREQ_CONFIG_ADDR:   regRdata_reg <= freqConfig_reg;
        default:                        regRdata_reg <= 8'h00;
      endcase
    end
  end

  // Read data leaves straight from its register.
  assign regRdata = regRdata_reg;

  // Peak limits come from the registers only when the lookup is disabled; otherwise the table codes pass.
  always_comb
  begin
    if (lookupDisable)
    begin
      primarySel   = peakLimits_reg[bb_seq_pkg::PRIMARY_LSB +: 4];
      secondarySel = peakLimits_reg[bb_seq_pkg::SECONDARY_LSB +: 4];
    end
    else
    begin
      primarySel   = lookupPrimary[3:0];
      secondarySel = lookupSecondary[3:0];
    end
  end

  // Comparator thresholds for the analog side.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      primaryPeakLimit <= 4'h0;
      totalPeakLimit   <= 5'h00;
    end
    else
    begin
      primaryPeakLimit <= primarySel;
      totalPeakLimit   <= 5'({1'b0, primarySel} + {1'b0, secondarySel});
    end
  end

  // Phase timers: the timeout ends a charge phase and the freewheel count sets the shortest phase 4.
  assign timeout       = (timer_reg >= TW'(TIMEOUT_CYC - 1));
  assign freewheelDone = (timer_reg >= TW'(FREEWHEEL_CYC - 1));

  // The charge phase that opens a cycle depends on the topology.
  assign chargeEntry = buckOnly ? bb_seq_pkg::PH_CHARGE1 : bb_seq_pkg::PH_CHARGE2;

  // Next phase from comparators, mode and timers.
  always_comb
  begin
    phase_next = phase_reg;
    case (phase_reg)
      bb_seq_pkg::PH_IDLE:
        if (chargeRequest)
          phase_next = chargeEntry;
      bb_seq_pkg::PH_CHARGE2:
        if (peakReached)
          phase_next = bb_seq_pkg::PH_CHARGE1;
      bb_seq_pkg::PH_CHARGE1:
        if (buckOnly)
        begin
          if (peakReached)
            phase_next = bb_seq_pkg::PH_DISCHARGE3;
        end
        else if (supplyAboveOutput)
        begin
          if (peakReached || timeout)
            phase_next = bb_seq_pkg::PH_DISCHARGE3;
        end
        else if (timeout || valleyReached)
          phase_next = bb_seq_pkg::PH_DISCHARGE3;
      bb_seq_pkg::PH_DISCHARGE3:
        if (zeroCrossed)
          phase_next = bb_seq_pkg::PH_FREEWHEEL4;
        else if (valleyReached)
        begin
          if (zeroCrossSel)
            phase_next = bb_seq_pkg::PH_FREEWHEEL4;
          else if (chargeRequest)
            phase_next = chargeEntry;
          else
            phase_next = bb_seq_pkg::PH_FREEWHEEL4;
        end
      bb_seq_pkg::PH_FREEWHEEL4:
        if (chargeRequest && freewheelDone)
          phase_next = chargeEntry;
      default:
        phase_next = bb_seq_pkg::PH_IDLE;
    endcase
  end

  // Any step of the state restarts the phase timer.
  assign phaseChange = (phase_next != phase_reg);

  // One switching cycle per entry into a charge phase; the step from phase 2 to phase 1 is inside a cycle.
  always_comb
  begin
    cycleStartPulse = 1'b0;
    if (phaseChange && (phase_next == bb_seq_pkg::PH_CHARGE1 || phase_next == bb_seq_pkg::PH_CHARGE2))
    begin
      case (phase_reg)
        bb_seq_pkg::PH_IDLE,
        bb_seq_pkg::PH_DISCHARGE3,
        bb_seq_pkg::PH_FREEWHEEL4: cycleStartPulse = 1'b1;
        default:                   cycleStartPulse = 1'b0;
      endcase
    end
  end

  // Phase state register.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      phase_reg <= bb_seq_pkg::PH_IDLE;
    else
      phase_reg <= phase_next;
  end

  // Time spent in the current phase, restarted on each change and saturating.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      timer_reg <= '0;
    else if (phaseChange)
      timer_reg <= '0;
    else if (!timeout)
      timer_reg <= timer_reg + 1'b1;
  end

  // Switch pairs per phase; each pattern but SW_OFF in idle holds exactly two switches.
  always_comb
  begin
    case (phase_next)
      bb_seq_pkg::PH_CHARGE1:    switchesNext = bb_seq_pkg::SW_PHASE1;
      bb_seq_pkg::PH_CHARGE2:    switchesNext = bb_seq_pkg::SW_PHASE2;
      bb_seq_pkg::PH_DISCHARGE3: switchesNext = bb_seq_pkg::SW_PHASE3;
      bb_seq_pkg::PH_FREEWHEEL4: switchesNext = bb_seq_pkg::SW_PHASE4;
      default:                   switchesNext = bb_seq_pkg::SW_OFF;
    endcase
  end

  // Switch drive registered from the next phase, so each pattern comes out whole on one edge.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      switches_reg <= bb_seq_pkg::SW_OFF;
    else
      switches_reg <= switchesNext;
  end

  // Phase number taken from the same next phase on the same edge, so it never disagrees with the switches.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      phaseNumber <= 3'd0;
    else
    begin
      case (phase_next)
        bb_seq_pkg::PH_CHARGE1:    phaseNumber <= 3'd1;
        bb_seq_pkg::PH_CHARGE2:    phaseNumber <= 3'd2;
        bb_seq_pkg::PH_DISCHARGE3: phaseNumber <= 3'd3;
        bb_seq_pkg::PH_FREEWHEEL4: phaseNumber <= 3'd4;
        default:                   phaseNumber <= 3'd0;
      endcase
    end
  end

  // Gate outputs in the order input high, output high, input low, output low.
  assign inputHighSwitch  = switches_reg[3];
  assign outputHighSwitch = switches_reg[2];
  assign inputLowSwitch   = switches_reg[1];
  assign outputLowSwitch  = switches_reg[0];

  // Frequency comparator hookup.
  assign fm.cycleStart = cycleStartPulse;
  assign fm.fastSelect = freqConfig_reg[bb_seq_pkg::FAST_SEL_LSB +: bb_seq_pkg::FAST_SEL_WIDTH];
  assign lowQuiescent  = fm.lowQuiescent;

  freq_monitor #(
    .WINDOW_CYC (WINDOW_CYC)
  ) u_freq_monitor (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .mon     (fm.mon)
  );

endmodule

// ### verilog/bb_seq_pkg.sv
// Package of register offsets, field positions, reset values and timing counts for the phase sequencer.
package bb_seq_pkg;

  // Register offsets on the documented register port.
  localparam logic [7:0] MODE_CONFIG_ADDR   = 8'h31;
  localparam logic [7:0] PEAK_LIMITS_ADDR   = 8'h33;
  localparam logic [7:0] VALLEY_CONFIG_ADDR = 8'h34;
  localparam logic [7:0] FREQ_CONFIG_ADDR   = 8'h30;

  // Field positions.
  localparam int TOPOLOGY_BIT     = 1;
  localparam int LOOKUP_DIS_BIT   = 0;
  localparam int ZERO_CROSS_BIT   = 5;
  localparam int PRIMARY_LSB      = 0;
  localparam int SECONDARY_LSB    = 4;
  localparam int FAST_SEL_LSB     = 0;
  localparam int FAST_SEL_WIDTH   = 2;

  // Reset values.
  localparam logic [7:0] MODE_CONFIG_RST   = 8'h00;
  localparam logic [7:0] PEAK_LIMITS_RST   = 8'h00;
  localparam logic [7:0] VALLEY_CONFIG_RST = 8'h00;
  localparam logic [7:0] FREQ_CONFIG_RST   = 8'h00;

  // Timing.
  localparam int CLK_MHZ          = 40;
  localparam int CHARGE_TIMEOUT_NS = 500;
  localparam int CHARGE_TIMEOUT_CYC = (CHARGE_TIMEOUT_NS * CLK_MHZ) / 1000;
  localparam int FREEWHEEL_NS     = 30;
  localparam int FREEWHEEL_CYC_RAW = (FREEWHEEL_NS * CLK_MHZ + 999) / 1000;
  localparam int FREEWHEEL_CYC    = (FREEWHEEL_CYC_RAW < 1) ? 1 : FREEWHEEL_CYC_RAW;

  // Frequency measurement window in clock cycles and base fast threshold in pulses per window.
  localparam int FREQ_WINDOW_CYC  = 4000;
  localparam int FAST_BASE_COUNT  = 16;

  // Switch enable vector order: input high, output high, input low, output low.
  localparam logic [3:0] SW_OFF    = 4'h0;
  localparam logic [3:0] SW_PHASE1 = 4'b1100;
  localparam logic [3:0] SW_PHASE2 = 4'b1001;
  localparam logic [3:0] SW_PHASE3 = 4'b0110;
  localparam logic [3:0] SW_PHASE4 = 4'b0011;

  // Switching phase states.
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_CHARGE2,
    PH_CHARGE1,
    PH_DISCHARGE3,
    PH_FREEWHEEL4
  } phase_e;

endpackage

// ### verilog/freq_monitor_if.sv
// Interface carrying switching-cycle events and the low-quiescent decision between sequencer and monitor.
`timescale 1ns/100ps
interface freq_monitor_if;
  logic       cycleStart;
  logic [1:0] fastSelect;
  logic       lowQuiescent;

  modport seq (output cycleStart, output fastSelect, input lowQuiescent);
  modport mon (input cycleStart, input fastSelect, output lowQuiescent);
endinterface

// ### verilog/freq_monitor.sv
// Switching-frequency comparator with hysteresis that controls the low-quiescent state.
`timescale 1ns/100ps
module freq_monitor #(
  parameter int WINDOW_CYC = bb_seq_pkg::FREQ_WINDOW_CYC
) (
  input wire logic   ref_clk,
  input wire logic   rst_b,
  freq_monitor_if.mon mon
);

  localparam int CW = $clog2(WINDOW_CYC + 1);

  // Elaboration check: a shorter window cannot hold a meaningful count.
  if (WINDOW_CYC < 8)
  begin : g_windowCheck
    $error("freq_monitor: window too short");
  end

  logic [CW-1:0] windowCnt_reg;
  logic [11:0]   pulseCnt_reg;
  logic          lowQ_reg;
  logic [11:0]   fastCount;
  logic          windowEnd;

  // Fast threshold scales with the select field; the return threshold is a quarter of it.
  assign fastCount = 12'(bb_seq_pkg::FAST_BASE_COUNT) << mon.fastSelect;
  assign windowEnd = (windowCnt_reg == CW'(WINDOW_CYC - 1));
  assign mon.lowQuiescent = lowQ_reg;

  // Measurement window timer.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      windowCnt_reg <= '0;
    else if (windowEnd)
      windowCnt_reg <= '0;
    else
      windowCnt_reg <= windowCnt_reg + 1'b1;
  end

  // Counts switching cycles started within the window, saturating.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      pulseCnt_reg <= '0;
    else if (windowEnd)
      pulseCnt_reg <= 12'(mon.cycleStart);
    else if (mon.cycleStart && pulseCnt_reg != 12'hFFF)
      pulseCnt_reg <= pulseCnt_reg + 1'b1;
  end

  // Leaves low-quiescent at the fast rate and returns only at a quarter of it.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      lowQ_reg <= 1'b1;
    else if (windowEnd)
    begin
      if (lowQ_reg && pulseCnt_reg >= fastCount)
        lowQ_reg <= 1'b0;
      else if (!lowQ_reg && pulseCnt_reg <= (fastCount >> 2))
        lowQ_reg <= 1'b1;
    end
  end

endmodule

// ### tb/buck_boost_phase_sequencer_properties.sv
// Checker of switch pairs and phase timing at the sequencer's ports.
`timescale 1ns/100ps
module buck_boost_phase_sequencer_properties #(
  parameter int TIMEOUT_CYC   = 20,
  parameter int FREEWHEEL_CYC = 2
) (
  input wire logic       ref_clk,
  input wire logic       rst_b,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic       regWrite,
  input wire logic       peakReached,
  input wire logic       supplyAboveOutput,
  input wire logic       chargeRequest,
  input wire logic       inputHighSwitch,
  input wire logic       outputHighSwitch,
  input wire logic       inputLowSwitch,
  input wire logic       outputLowSwitch,
  input wire logic [2:0] phaseNumber
);
  localparam logic [3:0] PAIRS [8] = '{4'h0, 4'hC, 4'h9, 4'h6, 4'h3, 4'hF, 4'hF, 4'hF};
  logic       buckOnly_reg;
  logic [7:0] chargeCnt_reg;
  logic [7:0] freeCnt_reg;
  logic [3:0] sw;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Mirrors the topology bit and counts cycles spent in phases 1 and 4; the freewheel count saturates.
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      buckOnly_reg  <= 1'b0;
      chargeCnt_reg <= 8'h00;
      freeCnt_reg   <= 8'h00;
    end
    else
    begin
      if (regWrite && regAddr == 8'h31)
        buckOnly_reg <= regWdata[1];
      chargeCnt_reg <= (phaseNumber == 3'h1) ? chargeCnt_reg + 8'h01 : 8'h00;
      if (phaseNumber != 3'h4)
        freeCnt_reg <= 8'h00;
      else if (freeCnt_reg != 8'hFF)
        freeCnt_reg <= freeCnt_reg + 8'h01;
    end
  end

  // Gate vector in the order input high, output high, input low, output low.
  assign sw = {inputHighSwitch, outputHighSwitch, inputLowSwitch, outputLowSwitch};

  property p_switch_limit; $countones(sw) <= 2; endproperty
  a_switch_limit: assert property (p_switch_limit) else $error("Too many switches on.");
  property p_phase_pairs; sw == PAIRS[phaseNumber]; endproperty
  a_phase_pairs: assert property (p_phase_pairs) else $error("Wrong switch pair.");
  property p_charge2_hold; phaseNumber == 3'h2 && !peakReached |=> phaseNumber == 3'h2; endproperty
  a_charge2_hold: assert property (p_charge2_hold) else $error("Left phase 2 early.");
  property p_charge2_exit; phaseNumber == 3'h2 && peakReached |=> phaseNumber == 3'h1; endproperty
  a_charge2_exit: assert property (p_charge2_exit) else $error("Phase 2 did not go to 1.");
  property p_timeout; !buckOnly_reg |-> chargeCnt_reg <= TIMEOUT_CYC + 1; endproperty
  a_timeout: assert property (p_timeout) else $error("Phase 1 over time.");
  property p_phase1_exit;
    phaseNumber == 3'h1 && peakReached && (buckOnly_reg || supplyAboveOutput) |=> phaseNumber == 3'h3;
  endproperty
  a_phase1_exit: assert property (p_phase1_exit) else $error("Phase 1 did not go to 3.");
  property p_freewheel_min; phaseNumber != 3'h4 && freeCnt_reg != 8'h00 |-> freeCnt_reg >= FREEWHEEL_CYC; endproperty
  a_freewheel_min: assert property (p_freewheel_min) else $error("Phase 4 too short.");
  property p_wait_request; phaseNumber == 3'h4 && !chargeRequest |=> phaseNumber == 3'h4; endproperty
  a_wait_request: assert property (p_wait_request) else $error("Charge without request.");
endmodule

bind buck_boost_phase_sequencer buck_boost_phase_sequencer_properties #(.TIMEOUT_CYC(TIMEOUT_CYC),
  .FREEWHEEL_CYC(FREEWHEEL_CYC)) u_props (.ref_clk, .rst_b, .regAddr, .regWdata, .regWrite, .peakReached,
  .supplyAboveOutput, .chargeRequest, .inputHighSwitch, .outputHighSwitch, .inputLowSwitch, .outputLowSwitch,
  .phaseNumber);

// ### tb/converter_plant_model.sv
// Behavioural inductor model that drives the current comparators.
`timescale 1ns/100ps
module converter_plant_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic [2:0] phaseNumber,
  input  wire logic [3:0] primaryPeakLimit,
  input  wire logic [4:0] totalPeakLimit,
  input  wire logic       supplyAboveOutput,
  input  wire logic       buckOnly,
  output logic            peakReached,
  output logic            valleyReached,
  output logic            zeroCrossed
);
  int coilLevel_reg;

  // Coil current in limit units: phase 2 raises it, phase 1 raises it above the output or buck-only and holds it otherwise, phase 3 lowers it, freewheel clears it.
  always @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      coilLevel_reg <= 0;
    else if (phaseNumber == 3'h2 || (phaseNumber == 3'h1 && (supplyAboveOutput || buckOnly)))
      coilLevel_reg <= coilLevel_reg + 1;
    else if (phaseNumber == 3'h3)
      coilLevel_reg <= coilLevel_reg - 1;
    else if (phaseNumber != 3'h1)
      coilLevel_reg <= 0;
  end

  // Peak is judged against the limit of the phase; valley trips one unit above zero, before the zero crossing.
  assign peakReached = (phaseNumber == 3'h2 && coilLevel_reg >= int'(primaryPeakLimit)) ||
    (phaseNumber == 3'h1 && coilLevel_reg >= int'(buckOnly ? {1'b0, primaryPeakLimit} : totalPeakLimit));
  assign valleyReached = phaseNumber == 3'h3 && coilLevel_reg <= 1;
  assign zeroCrossed = phaseNumber == 3'h3 && coilLevel_reg <= 0;
endmodule

// ### tb/tb_buck_boost_phase_sequencer.sv
// Self-checking bench of the buck-boost phase sequencer driving a plant model.
`timescale 1ns/100ps
module tb_buck_boost_phase_sequencer;
  localparam int TIMEOUT_CYC = 20;
  localparam int WINDOW_CYC  = 256;
  typedef struct {
    logic [7:0] addr, wdata, rdExp, lookP, lookS, priExp, totExp;
  } reg_row_s;
  reg_row_s rows [7] = '{
    '{8'h33, 8'h53, 8'h53, 8'h07, 8'h02, 8'h07, 8'h09},
    '{8'h31, 8'h01, 8'h01, 8'h07, 8'h02, 8'h03, 8'h08},
    '{8'h33, 8'hFF, 8'hFF, 8'h07, 8'h02, 8'h0F, 8'h1E},
    '{8'h34, 8'h20, 8'h20, 8'h07, 8'h02, 8'h0F, 8'h1E},
    '{8'h30, 8'h03, 8'h03, 8'h07, 8'h02, 8'h0F, 8'h1E},
    '{8'h32, 8'hAA, 8'h00, 8'h07, 8'h02, 8'h0F, 8'h1E},
    '{8'h31, 8'h00, 8'h00, 8'h0A, 8'h04, 8'h0A, 8'h0E}};
  logic       ref_clk, rst_b, regWrite, regRead, peakReached, valleyReached, zeroCrossed;
  logic       supplyAboveOutput, chargeRequest, buckOnly, lowQuiescent;
  logic       inputHighSwitch, outputHighSwitch, inputLowSwitch, outputLowSwitch;
  logic [7:0] regAddr, regWdata, regRdata, lookupPrimary, lookupSecondary, rdVal;
  logic [3:0] primaryPeakLimit;
  logic [4:0] totalPeakLimit;
  logic [2:0] phaseNumber;
  int         dwell [4];
  int         errTotal, checks, cycles;

  buck_boost_phase_sequencer #(.TIMEOUT_CYC(TIMEOUT_CYC), .FREEWHEEL_CYC(2), .WINDOW_CYC(WINDOW_CYC)) u_dut (
    .ref_clk, .rst_b, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .lookupPrimary, .lookupSecondary,
    .primaryPeakLimit, .totalPeakLimit, .peakReached, .valleyReached, .zeroCrossed, .supplyAboveOutput,
    .chargeRequest, .inputHighSwitch, .outputHighSwitch, .inputLowSwitch, .outputLowSwitch, .phaseNumber,
    .lowQuiescent);
  converter_plant_model u_plant (.ref_clk, .rst_b, .phaseNumber, .primaryPeakLimit, .totalPeakLimit,
    .supplyAboveOutput, .buckOnly, .peakReached, .valleyReached, .zeroCrossed);

  // Free-running 40 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Prints the verdict and ends the run.
  task automatic tallyAndFinish;
    if (errTotal == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Compares one byte-wide result.
  task automatic chk(input logic [7:0] expV, input logic [7:0] gotV);
    checks++;
    if (gotV !== expV)
    begin
      errTotal++;
      $display("BAD %0t got %h expected %h", $time, gotV, expV);
    end
  endtask

  // Register writes and reads hold their strobe for one clock edge.
  task automatic regWr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge ref_clk);
    regAddr = addr;
    regWdata = data;
    regWrite = 1'b1;
    @(negedge ref_clk);
    regWrite = 1'b0;
  endtask
  task automatic regRd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge ref_clk);
    regAddr = addr;
    regRead = 1'b1;
    @(negedge ref_clk);
    regRead = 1'b0;
    data = regRdata;
  endtask

  // Follows the next phase changes, checks them against a nibble list and records the dwell of each phase but the last.
  task automatic runSeq(input int n, input logic [15:0] expSeq);
    int k;
    int cnt;
    logic [2:0] last;
    k = 0;
    cnt = 0;
    last = phaseNumber;
    for (int t = 0; t < 300 && k < n; t++)
    begin
      @(negedge ref_clk);
      cnt++;
      if (phaseNumber !== last)
      begin
        if (k > 0)
          dwell[k - 1] = cnt;
        chk({4'h0, expSeq[12 - 4 * k +: 4]}, {5'h00, phaseNumber});
        k++;
        cnt = 0;
        last = phaseNumber;
      end
    end
    chk(8'(n), 8'(k));
  endtask

  // Cuts a hung run short.
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      errTotal++;
      tallyAndFinish();
    end
  end

  // Register table first, then phase sequences, the frequency monitor and a reset in mid-run.
  initial
  begin
    {regAddr, regWdata, regWrite, regRead, chargeRequest, buckOnly, lookupPrimary, lookupSecondary} = '0;
    supplyAboveOutput = 1'b1;
    rst_b = 1'b0;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    foreach (rows[i])
    begin
      lookupPrimary = rows[i].lookP;
      lookupSecondary = rows[i].lookS;
      regWr(rows[i].addr, rows[i].wdata);
      regRd(rows[i].addr, rdVal);
      chk(rows[i].rdExp, rdVal);
      repeat (2) @(negedge ref_clk);
      chk(rows[i].priExp, {4'h0, primaryPeakLimit});
      chk(rows[i].totExp, {3'h0, totalPeakLimit});
    end
    regWr(8'h31, 8'h01);
    regWr(8'h33, 8'h12);
    regWr(8'h30, 8'h00);
    supplyAboveOutput = 1'b0;
    chargeRequest = 1'b1;
    runSeq(4, 16'h2134);
    chk(8'h01, {7'h00, dwell[1] inside {[TIMEOUT_CYC:TIMEOUT_CYC + 1]}});
    chargeRequest = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk(8'h04, {5'h00, phaseNumber});
    supplyAboveOutput = 1'b1;
    chargeRequest = 1'b1;
    runSeq(4, 16'h2134);
    chargeRequest = 1'b0;
    regWr(8'h34, 8'h00);
    chargeRequest = 1'b1;
    runSeq(4, 16'h2132);
    chargeRequest = 1'b0;
    repeat (40) @(negedge ref_clk);
    regWr(8'h34, 8'h20);
    regWr(8'h31, 8'h03);
    buckOnly = 1'b1;
    chargeRequest = 1'b1;
    runSeq(3, 16'h1340);
    chargeRequest = 1'b0;
    repeat (40) @(negedge ref_clk);
    regWr(8'h31, 8'h01);
    buckOnly = 1'b0;
    regWr(8'h33, 8'h01);
    chargeRequest = 1'b1;
    repeat (3 * WINDOW_CYC) @(negedge ref_clk);
    chk(8'h00, {7'h00, lowQuiescent});
    regWr(8'h30, 8'h02);
    repeat (3 * WINDOW_CYC) @(negedge ref_clk);
    chk(8'h00, {7'h00, lowQuiescent});
    chargeRequest = 1'b0;
    repeat (3 * WINDOW_CYC) @(negedge ref_clk);
    chk(8'h01, {7'h00, lowQuiescent});
    regWr(8'h30, 8'h03);
    chargeRequest = 1'b1;
    repeat (3 * WINDOW_CYC) @(negedge ref_clk);
    chk(8'h01, {7'h00, lowQuiescent});
    rst_b = 1'b0;
    @(negedge ref_clk);
    chk(8'h10, {3'h0, lowQuiescent, inputHighSwitch, outputHighSwitch, inputLowSwitch, outputLowSwitch});
    chk(8'h00, {5'h00, phaseNumber});
    rst_b = 1'b1;
    for (int a = 8'h30; a < 8'h35; a++)
    begin
      regRd(8'(a), rdVal);
      chk(8'h00, rdVal);
    end
    chargeRequest = 1'b0;
    tallyAndFinish();
  end
endmodule
